/* src/wleu_top.sv */
// Purpose: Execution of the word load family: fpu, cop2, user-space, left-part and pc-relative loads
// Assumes: Upstream predecode gives the op kind; pc-relative loads are decoded here from the word
// Notes:   One load in flight; the memory path holds its answer until taken
// Summary of operation
// [RL1] Fpu word load: only refill, invalid, address, reserved, unusable, watch; raw word
// [RL2] Cop2 load fetches word at base plus signed offset into low cop2 word
// [RL3] Cop2 offset is 11 bits in newest release, 16 bits before
// [RL4] Before newest release, misaligned word load raises address error
// [RL5] Newest release passes misaligned word load addresses to memory path
// [RL6] User word load: 9-bit offset, user mapping, three user segment modes
// [RL7] User loads need cop0 access and a user segment, else reserved or unusable; a kernel-segment answer carrying read inhibit is written back
// [RL8] User loads exist only when extended addressing enable reads one
// [RL9] Left load address is base plus 16-bit offset, naming most significant byte
// [RL10] Left load fills upper register bytes from aligned word, lower kept
// [RL11] Partial load byte choice uses low address bits and byte order
// [RL12] Newest release has no left/right loads; misaligned access in hardware
// [RL13] Left load reports only refill, invalid, bus, address or watch
// [RL14] User left load: 9-bit offset, left merge, user load gating
// [RL15] Pc-relative load decoded by major 111011, sub 01, 19-bit offset
// [RL16] Pc-relative address is own pc plus sign-extended offset shifted two
// [RL17] Pc-relative load writes fetched word into register field register
// [RL18] Pc-relative load address is always word aligned
// [RL19] Pc-relative load raises refill, invalid, read inhibit, bus, address, watch
// [RL20] Pc-relative load counts as data reference for watch logic
// [RL21] Left lanes from low address bits xor big-endian; low bytes kept
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "wleu_params.svh"

module wleu_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    issue_valid,
  input  wire wleu_pkg::wleu_issue_s   issue,
  output logic                         issue_ready,
  output logic                         mem_req_valid,
  output wleu_pkg::wleu_mem_req_s      mem_req,
  input  wire logic                    mem_resp_valid,
  input  wire wleu_pkg::wleu_mem_resp_s mem_resp,
  output logic                         wb_valid,
  output wleu_pkg::wleu_wb_s           wb,
  output logic                         exc_valid,
  output wleu_pkg::wleu_exc_e          exc_code
);
  import wleu_pkg::*;

  logic [31:0]   ctrl_ff;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;
  wleu_state_e   state_ff;
  wleu_state_e   nxt_state;
  wleu_op_e      op_ff;
  logic [31:0]   old_ff;
  logic [4:0]    idx_ff;
  logic [1:0]    lane_ff;
  logic          ready_ff;
  logic          req_valid_ff;
  wleu_mem_req_s req_ff;
  logic          wb_valid_ff;
  wleu_wb_s      wb_ff;
  logic          exc_valid_ff;
  wleu_exc_e     exc_code_ff;
  wleu_exc_e     last_exc_ff;
  logic [15:0]   done_cnt_ff;

  logic          cfg_r6;
  logic          cfg_big;
  logic          cfg_eva;
  logic          cfg_cop0;
  logic          cfg_cop1;
  logic          cfg_cop2;
  logic          cfg_watch;
  logic          accept;
  logic          is_pc_relative_major_opcode;
  wleu_op_e      op_eff;
  logic [31:0]   offset;
  logic [31:0]   eff_addr;
  wleu_exc_e     issue_exc;
  wleu_exc_e     resp_exc;
  logic          resp_take;
  logic          apb_access;
  logic          apb_wr;
  logic [31:0]   rd_value;
  logic          rd_hit;

  assign cfg_r6    = ctrl_ff[`WLEU_CTRL_R6_BIT];
  assign cfg_big   = ctrl_ff[`WLEU_CTRL_BIG_BIT];
  assign cfg_eva   = ctrl_ff[`WLEU_CTRL_EVA_BIT];
  assign cfg_cop0  = ctrl_ff[`WLEU_CTRL_COP0_BIT];
  assign cfg_cop1  = ctrl_ff[`WLEU_CTRL_COP1_BIT];
  assign cfg_cop2  = ctrl_ff[`WLEU_CTRL_COP2_BIT];
  assign cfg_watch = ctrl_ff[`WLEU_CTRL_WATCH_BIT];

  // Register bus: one wait state so every answer comes from a flip-flop
  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pready_ff && pwrite;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    if (paddr == `WLEU_CTRL_OFF) begin
      rd_value = ctrl_ff;
    end else if (paddr == `WLEU_STATUS_OFF) begin
      rd_value = {done_cnt_ff, 8'h00, last_exc_ff, 3'b000, (state_ff != WLEU_ST_IDLE)};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= apb_access && !pready_ff;
      prdata_ff  <= (apb_access && !pready_ff && !pwrite) ? rd_value : 32'h0000_0000;
      pslverr_ff <= apb_access && !pready_ff && !rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `WLEU_CTRL_RESET;
    end else if (apb_wr && (paddr == `WLEU_CTRL_OFF)) begin
      ctrl_ff <= pwdata & `WLEU_CTRL_WMASK;
    end
  end

  // Decode and effective address
  assign accept   = issue_valid && ready_ff;
  assign is_pc_relative_major_opcode = (issue.instr[31:26] == `WLEU_PC_RELATIVE_MAJOR_OPCODE_MAJOR) &&
                    (issue.instr[20:19] == `WLEU_PC_RELATIVE_MAJOR_OPCODE_SUB_WORD); // [RL15]
  assign op_eff   = is_pc_relative_major_opcode ? WLEU_OP_PC_RELATIVE_MAJOR_OPCODE : issue.op;

  always_comb begin
    offset   = 32'h0000_0000;
    eff_addr = 32'h0000_0000;
    case (op_eff)
      WLEU_OP_COP2: begin
        if (cfg_r6) begin
          offset = {{21{issue.instr[10]}}, issue.instr[10:0]}; // [RL3]
        end else begin
          offset = {{16{issue.instr[15]}}, issue.instr[15:0]}; // [RL3]
        end
        eff_addr = issue.base + offset; // [RL2]
      end
      WLEU_OP_USER_WORD, WLEU_OP_USER_LEFT: begin
        offset   = {{23{issue.instr[15]}}, issue.instr[15:7]}; // [RL6] [RL14]
        eff_addr = issue.base + offset;
      end
      WLEU_OP_PC_RELATIVE_MAJOR_OPCODE: begin
        offset   = {{11{issue.instr[18]}}, issue.instr[18:0], 2'b00}; // [RL16]
        eff_addr = issue.pc + offset; // [RL16] [RL18]
      end
      default: begin
        offset   = {{16{issue.instr[15]}}, issue.instr[15:0]}; // [RL9]
        eff_addr = issue.base + offset;
      end
    endcase
  end

  // Traps decided before memory: reserved beats unusable beats alignment
  always_comb begin
    issue_exc = WLEU_EXC_NONE;
    case (op_eff)
      WLEU_OP_FPU: begin
        if (!cfg_cop1) begin
          issue_exc = WLEU_EXC_COP_UNUSABLE;
        end else if (!cfg_r6 && (eff_addr[1:0] != 2'b00)) begin
          issue_exc = WLEU_EXC_ADDR_ERROR; // [RL4]
        end
      end
      WLEU_OP_COP2: begin
        if (!cfg_cop2) begin
          issue_exc = WLEU_EXC_COP_UNUSABLE;
        end else if (!cfg_r6 && (eff_addr[1:0] != 2'b00)) begin
          issue_exc = WLEU_EXC_ADDR_ERROR; // [RL4]
        end
      end
      WLEU_OP_USER_WORD: begin
        if (!cfg_eva) begin
          issue_exc = WLEU_EXC_RESERVED; // [RL8]
        end else if (!cfg_cop0) begin
          issue_exc = WLEU_EXC_COP_UNUSABLE; // [RL7]
        end else if (!cfg_r6 && (eff_addr[1:0] != 2'b00)) begin
          issue_exc = WLEU_EXC_ADDR_ERROR; // [RL4]
        end
      end
      WLEU_OP_LEFT: begin
        if (cfg_r6) begin
          issue_exc = WLEU_EXC_RESERVED; // [RL12]
        end
      end
      WLEU_OP_USER_LEFT: begin
        if (cfg_r6 || !cfg_eva) begin
          issue_exc = WLEU_EXC_RESERVED; // [RL12] [RL14]
        end else if (!cfg_cop0) begin
          issue_exc = WLEU_EXC_COP_UNUSABLE; // [RL14]
        end
      end
      WLEU_OP_PC_RELATIVE_MAJOR_OPCODE: begin
        if (!cfg_r6) begin
          issue_exc = WLEU_EXC_RESERVED;
        end
      end
      default: begin
        issue_exc = WLEU_EXC_RESERVED;
      end
    endcase
  end

  // Memory answer filtered to the faults each load may raise
  assign resp_take = (state_ff == WLEU_ST_MEM) && mem_resp_valid;

  always_comb begin
    resp_exc = mem_resp.fault;
    if ((mem_resp.fault == WLEU_EXC_WATCH) && !cfg_watch) begin
      resp_exc = WLEU_EXC_NONE; // [RL20]
    end
    case (op_ff)
      WLEU_OP_FPU, WLEU_OP_COP2: begin
        if ((resp_exc == WLEU_EXC_BUS_ERROR) || (resp_exc == WLEU_EXC_READ_INHIBIT)) begin
          resp_exc = WLEU_EXC_NONE; // [RL1]
        end
      end
      WLEU_OP_USER_WORD, WLEU_OP_USER_LEFT: begin
        if (resp_exc == WLEU_EXC_READ_INHIBIT) begin
          resp_exc = WLEU_EXC_NONE;
        end else if (mem_resp.seg == WLEU_SEG_KERNEL) begin
          resp_exc = WLEU_EXC_RESERVED; // [RL7]
        end
      end
      WLEU_OP_LEFT: begin
        if (resp_exc == WLEU_EXC_READ_INHIBIT) begin
          resp_exc = WLEU_EXC_NONE; // [RL13]
        end
      end
      default: begin
        resp_exc = resp_exc; // [RL19]
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      WLEU_ST_IDLE: begin
        if (accept && (issue_exc == WLEU_EXC_NONE)) begin
          nxt_state = WLEU_ST_MEM;
        end
      end
      WLEU_ST_MEM: begin
        if (mem_resp_valid) begin
          nxt_state = WLEU_ST_IDLE;
        end
      end
      default: begin
        nxt_state = WLEU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= WLEU_ST_IDLE;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ready_ff <= (nxt_state == WLEU_ST_IDLE);
    end
  end

  // Context kept for the merge and the write-back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_ff   <= WLEU_OP_NONE;
      old_ff  <= 32'h0000_0000;
      idx_ff  <= 5'h00;
      lane_ff <= 2'b00;
    end else if (accept) begin
      op_ff   <= op_eff;
      old_ff  <= issue.old;
      idx_ff  <= is_pc_relative_major_opcode ? issue.instr[25:21] : issue.instr[20:16]; // [RL17]
      lane_ff <= eff_addr[1:0] ^ {2{cfg_big}}; // [RL11] [RL21]
    end
  end

  // Request stands unchanged until the memory path answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_valid_ff <= 1'b0;
      req_ff       <= '0;
    end else if (accept && (issue_exc == WLEU_EXC_NONE)) begin
      req_valid_ff  <= 1'b1;
      req_ff.addr   <= ((op_eff == WLEU_OP_LEFT) || (op_eff == WLEU_OP_USER_LEFT)) ?
                       {eff_addr[31:2], 2'b00} : eff_addr; // [RL5] [RL10]
      req_ff.user_map <= (op_eff == WLEU_OP_USER_WORD) || (op_eff == WLEU_OP_USER_LEFT); // [RL6]
      req_ff.data_ref <= 1'b1; // [RL20]
    end else if (resp_take) begin
      req_valid_ff <= 1'b0;
    end
  end

  // Left merge: chosen bytes go high, the rest of the old value stays
  function automatic logic [31:0] wleu_left_merge(input logic [31:0] mem, input logic [31:0] old,
                                                  input logic [1:0] lane);
    logic [31:0] res;
    res = mem;
    case (lane)
      2'b00: res = {mem[7:0], old[23:0]};
      2'b01: res = {mem[15:0], old[15:0]};
      2'b10: res = {mem[23:0], old[7:0]};
      default: res = mem;
    endcase
    return res;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_valid_ff <= 1'b0;
      wb_ff       <= '0;
    end else begin
      wb_valid_ff <= resp_take && (resp_exc == WLEU_EXC_NONE);
      if (resp_take) begin
        wb_ff.idx <= idx_ff;
        case (op_ff)
          WLEU_OP_FPU: begin
            wb_ff.dest <= WLEU_DEST_FPR;
            wb_ff.data <= mem_resp.data; // [RL1]
          end
          WLEU_OP_COP2: begin
            wb_ff.dest <= WLEU_DEST_CP2;
            wb_ff.data <= mem_resp.data; // [RL2]
          end
          WLEU_OP_LEFT, WLEU_OP_USER_LEFT: begin
            wb_ff.dest <= WLEU_DEST_GPR;
            wb_ff.data <= wleu_left_merge(mem_resp.data, old_ff, lane_ff); // [RL10] [RL21]
          end
          default: begin
            wb_ff.dest <= WLEU_DEST_GPR;
            wb_ff.data <= mem_resp.data; // [RL17] [RL6]
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_valid_ff <= 1'b0;
      exc_code_ff  <= WLEU_EXC_NONE;
    end else if (accept && (issue_exc != WLEU_EXC_NONE)) begin
      exc_valid_ff <= 1'b1;
      exc_code_ff  <= issue_exc;
    end else if (resp_take && (resp_exc != WLEU_EXC_NONE)) begin
      exc_valid_ff <= 1'b1;
      exc_code_ff  <= resp_exc;
    end else begin
      exc_valid_ff <= 1'b0;
      exc_code_ff  <= WLEU_EXC_NONE;
    end
  end

  // Status: last trap and a wrapping count of loads written back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_exc_ff <= WLEU_EXC_NONE;
      done_cnt_ff <= 16'h0000;
    end else begin
      if (exc_valid_ff) begin
        last_exc_ff <= exc_code_ff;
      end
      if (wb_valid_ff) begin
        done_cnt_ff <= done_cnt_ff + 16'h0001;
      end
    end
  end

  assign prdata        = prdata_ff;
  assign pready        = pready_ff;
  assign pslverr       = pslverr_ff;
  assign issue_ready   = ready_ff;
  assign mem_req_valid = req_valid_ff;
  assign mem_req       = req_ff;
  assign wb_valid      = wb_valid_ff;
  assign wb            = wb_ff;
  assign exc_valid     = exc_valid_ff;
  assign exc_code      = exc_code_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pc_relative_major_opcode_issue;
    accept && is_pc_relative_major_opcode && cfg_r6;
  endsequence
  sequence s_req_up;
    req_valid_ff && (req_ff.addr == ($past(issue.pc) + {{11{$past(issue.instr[18])}},
                     $past(issue.instr[18:0]), 2'b00}));
  endsequence

  chk_pc_relative_major_opcode_address: assert property (s_pc_relative_major_opcode_issue |=> s_req_up) // [RL16]
    else $error("pc-relative address wrong");
  chk_pc_relative_major_opcode_aligned: assert property (req_valid_ff && (op_ff == WLEU_OP_PC_RELATIVE_MAJOR_OPCODE) |->
                                      req_ff.addr[1:0] == 2'b00) // [RL18]
    else $error("pc-relative request misaligned");
  chk_misalign_trap: assert property (accept && !cfg_r6 && (op_eff == WLEU_OP_FPU) && cfg_cop1 &&
                                      (eff_addr[1:0] != 2'b00) |=> exc_valid && (exc_code == WLEU_EXC_ADDR_ERROR)
                                      && !mem_req_valid) // [RL4]
    else $error("misaligned load not trapped");
  chk_left_removed: assert property (accept && cfg_r6 && (op_eff == WLEU_OP_LEFT) |=>
                                     exc_valid && (exc_code == WLEU_EXC_RESERVED)) // [RL12]
    else $error("left load in newest release not refused");
  chk_eva_absent: assert property (accept && !cfg_eva && (op_eff == WLEU_OP_USER_WORD) |=>
                                   exc_code == WLEU_EXC_RESERVED) // [RL8]
    else $error("user load without extended addressing");
  chk_req_holds: assert property (req_valid_ff && !mem_resp_valid |=> req_valid_ff && $stable(req_ff)) // [RL2]
    else $error("memory request dropped early");
  // A user load answered from a kernel segment is refused even when the watch hit is dropped
  chk_watch_gate: assert property (resp_take && (mem_resp.fault == WLEU_EXC_WATCH) && !cfg_watch &&
                                   !(req_ff.user_map && (mem_resp.seg == WLEU_SEG_KERNEL)) |=>
                                   wb_valid && !exc_valid) // [RL20]
    else $error("watch raised while data watch off");
  chk_fpu_no_bus: assert property (resp_take && (op_ff == WLEU_OP_FPU) |=> exc_code != WLEU_EXC_BUS_ERROR) // [RL1]
    else $error("fpu load reported bus error");
  chk_left_merge: assert property (resp_take && (op_ff == WLEU_OP_LEFT) && (lane_ff == 2'b01) &&
                                   (resp_exc == WLEU_EXC_NONE) |=> wb.data == {$past(mem_resp.data[15:0]),
                                   $past(old_ff[15:0])}) // [RL10]
    else $error("left merge lanes wrong");

endmodule

/* src/wleu_params.svh */
// Purpose: Offsets, field positions, reset values and opcode constants of the word load unit
// Assumes: Included by its bare name from design files
// Notes:   Definitions only
`ifndef WLEU_PARAMS_SVH
`define WLEU_PARAMS_SVH

`define WLEU_CTRL_OFF        12'h000
`define WLEU_STATUS_OFF      12'h004
`define WLEU_CTRL_RESET      32'h0000_0000
`define WLEU_CTRL_WMASK      32'h0000_007f

`define WLEU_CTRL_R6_BIT     0
`define WLEU_CTRL_BIG_BIT    1
`define WLEU_CTRL_EVA_BIT    2
`define WLEU_CTRL_COP0_BIT   3
`define WLEU_CTRL_COP1_BIT   4
`define WLEU_CTRL_COP2_BIT   5
`define WLEU_CTRL_WATCH_BIT  6

`define WLEU_PC_RELATIVE_MAJOR_OPCODE_MAJOR     6'h3b
`define WLEU_PC_RELATIVE_MAJOR_OPCODE_SUB_WORD  2'h1

`endif

/* src/wleu_pkg.sv */
// Purpose: Types shared by the word load unit and its bench
// Assumes: Nothing
// Notes:   Encodings are fixed, benches compare against them
package wleu_pkg;

  typedef enum logic [2:0] {
    WLEU_OP_NONE      = 3'b000,
    WLEU_OP_FPU       = 3'b001,
    WLEU_OP_COP2      = 3'b010,
    WLEU_OP_USER_WORD = 3'b011,
    WLEU_OP_LEFT      = 3'b100,
    WLEU_OP_USER_LEFT = 3'b101,
    WLEU_OP_PC_RELATIVE_MAJOR_OPCODE     = 3'b110
  } wleu_op_e;

  typedef enum logic [3:0] {
    WLEU_EXC_NONE         = 4'h0,
    WLEU_EXC_TLB_REFILL   = 4'h1,
    WLEU_EXC_TLB_INVALID  = 4'h2,
    WLEU_EXC_READ_INHIBIT = 4'h3,
    WLEU_EXC_BUS_ERROR    = 4'h4,
    WLEU_EXC_ADDR_ERROR   = 4'h5,
    WLEU_EXC_RESERVED     = 4'h6,
    WLEU_EXC_COP_UNUSABLE = 4'h7,
    WLEU_EXC_WATCH        = 4'h8
  } wleu_exc_e;

  typedef enum logic [1:0] {
    WLEU_SEG_KERNEL        = 2'b00,
    WLEU_SEG_USER_MAPPED   = 2'b01,
    WLEU_SEG_UNMAPPED_USER = 2'b10,
    WLEU_SEG_MAPPED_USER   = 2'b11
  } wleu_seg_e;

  typedef enum logic [1:0] {
    WLEU_DEST_GPR = 2'b00,
    WLEU_DEST_FPR = 2'b01,
    WLEU_DEST_CP2 = 2'b10
  } wleu_dest_e;

  typedef enum logic [1:0] {
    WLEU_ST_IDLE = 2'b00,
    WLEU_ST_MEM  = 2'b01
  } wleu_state_e;

  typedef struct packed {
    wleu_op_e    op;
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] base;
    logic [31:0] old;
  } wleu_issue_s;

  typedef struct packed {
    logic [31:0] addr;
    logic        user_map;
    logic        data_ref;
  } wleu_mem_req_s;

  typedef struct packed {
    wleu_exc_e   fault;
    wleu_seg_e   seg;
    logic [31:0] data;
  } wleu_mem_resp_s;

  typedef struct packed {
    wleu_dest_e  dest;
    logic [4:0]  idx;
    logic [31:0] data;
  } wleu_wb_s;

endpackage

/* tb/wleu_mem_model.sv */
// Purpose: Memory path partner that answers the load requests of the word load unit
// Assumes: Bench picks fault, segment mode and answer delay before each load
// Notes:   Data is a fixed function of the aligned address
`timescale 1ns/1ps
module wleu_mem_model (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     mem_req_valid,
  input  wire wleu_pkg::wleu_mem_req_s  mem_req,
  input  wire wleu_pkg::wleu_exc_e      fault_cfg,
  input  wire wleu_pkg::wleu_seg_e      seg_cfg,
  input  wire logic [1:0]               delay_cfg,
  output logic                          mem_resp_valid,
  output wleu_pkg::wleu_mem_resp_s      mem_resp
);
  import wleu_pkg::*;
  logic [1:0] wait_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_resp_valid <= 1'b0;
      mem_resp       <= '0;
      wait_ff        <= 2'h0;
    end else if (mem_resp_valid && mem_req_valid) begin
      // Inverted after release so a late sample cannot match by chance
      mem_resp_valid <= 1'b0;
      mem_resp.data  <= ~mem_resp.data;
      wait_ff        <= 2'h0;
    end else if (mem_req_valid && !mem_resp_valid) begin
      if (wait_ff == delay_cfg) begin
        mem_resp_valid <= 1'b1;
        mem_resp       <= '{fault_cfg, seg_cfg, {mem_req.addr[31:2], 2'h0} ^ 32'hc3a5_5a3c};
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench of the word load unit against a reference model
// Assumes: Memory path partner in wleu_mem_model
// Notes:   Random loads under random control settings from a fixed seed
`timescale 1ns/1ps
`include "wleu_params.svh"
module tb_top;
  import wleu_pkg::*;
  logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, ctrl, rd;
  logic           issue_valid, issue_ready, mem_req_valid, mem_resp_valid, wb_valid, exc_valid;
  wleu_issue_s    issue;
  wleu_mem_req_s  mem_req;
  wleu_mem_resp_s mem_resp;
  wleu_wb_s       wb;
  wleu_exc_e      exc_code, fault_cfg, last_exc, f;
  wleu_seg_e      seg_cfg;
  logic [1:0]     delay_cfg;
  logic [31:0]    r, instr;
  wleu_op_e       op;
  int             num_errors = 0, tests_run = 0, cycles = 0, wb_count = 0, seed = 32'hc332;
  wleu_exc_e      flts [8] = '{WLEU_EXC_NONE, WLEU_EXC_NONE, WLEU_EXC_TLB_REFILL, WLEU_EXC_TLB_INVALID,
                               WLEU_EXC_READ_INHIBIT, WLEU_EXC_BUS_ERROR, WLEU_EXC_ADDR_ERROR, WLEU_EXC_WATCH};

  wleu_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
                  .issue_valid, .issue, .issue_ready, .mem_req_valid, .mem_req, .mem_resp_valid, .mem_resp,
                  .wb_valid, .wb, .exc_valid, .exc_code);
  wleu_mem_model mem_u (.pclk, .presetn, .mem_req_valid, .mem_req, .fault_cfg, .seg_cfg, .delay_cfg,
                        .mem_resp_valid, .mem_resp);

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("Summary: %0d comparisons, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Called just after a rising edge; leaves one idle cycle so psel is never set twice at one edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    apb(1'b1, `WLEU_CTRL_OFF, v);
    ctrl = v & `WLEU_CTRL_WMASK;
    apb(1'b0, `WLEU_CTRL_OFF, 32'h0);
    chk("ctrl", ctrl, rd);
  endtask

  task automatic load(input wleu_op_e op, input logic [31:0] instr, input logic [31:0] base,
                      input logic [31:0] old, input wleu_exc_e flt, input wleu_seg_e sg);
    logic [31:0] pc, ea, ra, mem, dat;
    logic        r6, usr, lft, pcr, seen;
    wleu_exc_e   ex, fx;
    wleu_dest_e  dest;
    int          sh, n;
    pc  = $random(seed) & 32'hffff_fffc;
    r6  = ctrl[`WLEU_CTRL_R6_BIT];
    usr = op == WLEU_OP_USER_WORD || op == WLEU_OP_USER_LEFT;
    lft = op == WLEU_OP_LEFT || op == WLEU_OP_USER_LEFT;
    pcr = instr[31:26] == `WLEU_PC_RELATIVE_MAJOR_OPCODE_MAJOR && instr[20:19] == `WLEU_PC_RELATIVE_MAJOR_OPCODE_SUB_WORD;
    if (pcr) ea = pc + {{11{instr[18]}}, instr[18:0], 2'h0};
    else if (usr) ea = base + {{23{instr[15]}}, instr[15:7]};
    else if (op == WLEU_OP_COP2 && r6) ea = base + {{21{instr[10]}}, instr[10:0]};
    else ea = base + {{16{instr[15]}}, instr[15:0]};
    ex = WLEU_EXC_NONE;
    if ((pcr && !r6) || (usr && !ctrl[2]) || (lft && r6) || op == WLEU_OP_NONE)
      ex = WLEU_EXC_RESERVED;
    else if ((usr && !ctrl[3]) || (op == WLEU_OP_FPU && !ctrl[4]) || (op == WLEU_OP_COP2 && !ctrl[5]))
      ex = WLEU_EXC_COP_UNUSABLE;
    else if (!r6 && !lft && !pcr && ea[1:0] != 2'h0) ex = WLEU_EXC_ADDR_ERROR;
    ra  = lft ? {ea[31:2], 2'h0} : ea;
    mem = {ra[31:2], 2'h0} ^ 32'hc3a5_5a3c;
    fault_cfg   <= flt;
    seg_cfg     <= sg;
    delay_cfg   <= 2'($random(seed));
    issue_valid <= 1'b1;
    issue       <= '{op, instr, pc, base, old};
    do @(posedge pclk); while (issue_ready !== 1'b1);
    issue_valid <= 1'b0;
    seen = 1'b0;
    n    = 0;
    do begin
      @(posedge pclk);
      n++;
      if (mem_req_valid === 1'b1 && !seen) begin
        seen = 1'b1;
        chk("req_addr", ra, mem_req.addr);
        chk("req_flags", {30'h0, usr, 1'b1}, {30'h0, mem_req.user_map, mem_req.data_ref});
      end
    end while (wb_valid !== 1'b1 && exc_valid !== 1'b1 && n < 40);
    chk("mem_used", {31'h0, ex == WLEU_EXC_NONE}, {31'h0, seen});
    fx = flt;
    if ((op == WLEU_OP_FPU || op == WLEU_OP_COP2) && (fx == WLEU_EXC_BUS_ERROR || fx == WLEU_EXC_READ_INHIBIT))
      fx = WLEU_EXC_NONE;
    if ((usr || lft) && fx == WLEU_EXC_READ_INHIBIT) fx = WLEU_EXC_NONE;
    if (fx == WLEU_EXC_WATCH && !ctrl[`WLEU_CTRL_WATCH_BIT]) fx = WLEU_EXC_NONE;
    if (ex == WLEU_EXC_NONE) ex = (usr && fx == WLEU_EXC_NONE && sg == WLEU_SEG_KERNEL) ? WLEU_EXC_RESERVED : fx;
    chk("exc_code", {28'h0, ex}, {28'h0, exc_code});
    chk("wb_valid", {31'h0, ex == WLEU_EXC_NONE}, {31'h0, wb_valid});
    if (ex == WLEU_EXC_NONE) begin
      sh   = 24 - 8 * int'(ea[1:0] ^ {2{ctrl[`WLEU_CTRL_BIG_BIT]}});
      dat  = lft ? ((mem << sh) | (old & ((32'h1 << sh) - 32'h1))) : mem;
      dest = op == WLEU_OP_FPU ? WLEU_DEST_FPR : op == WLEU_OP_COP2 ? WLEU_DEST_CP2 : WLEU_DEST_GPR;
      chk("wb_data", dat, wb.data);
      chk("wb_dest", {25'h0, dest, pcr ? instr[25:21] : instr[20:16]}, {25'h0, wb.dest, wb.idx});
      wb_count++;
    end else begin
      last_exc = ex;
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    issue_valid = 1'b0;
    issue = '0;
    fault_cfg = WLEU_EXC_NONE;
    seg_cfg = WLEU_SEG_USER_MAPPED;
    delay_cfg = 2'h0;
    last_exc = WLEU_EXC_NONE;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, `WLEU_CTRL_OFF, 32'h0);
    chk("ctrl_reset", `WLEU_CTRL_RESET, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0, rd);
    apb(1'b1, `WLEU_STATUS_OFF, 32'hffff_ffff);
    apb(1'b0, `WLEU_STATUS_OFF, 32'h0);
    chk("status_ro", 32'h0, rd);
    // Every lane in both byte orders, plain and user-space merges
    for (int i = 0; i < 16; i++) begin
      if (i[2:0] == 3'h0) set_ctrl(i[3] ? 32'h7e : 32'h7c);
      r = $random(seed);
      load(i[2] ? WLEU_OP_USER_LEFT : WLEU_OP_LEFT, {11'h0, 5'(i), 16'h0}, {r[31:2], i[1:0]},
           $random(seed), WLEU_EXC_NONE, WLEU_SEG_USER_MAPPED);
    end
    for (int k = 0; k < 400; k++) begin
      if (k % 25 == 0) set_ctrl($random(seed));
      op    = wleu_op_e'(3'({$random(seed)} % 7));
      r     = $random(seed);
      instr = (op == WLEU_OP_PC_RELATIVE_MAJOR_OPCODE) ? {6'h3b, r[25:21], 2'h1, r[18:0]} : {6'h0, r[25:0]};
      r     = $random(seed);
      f     = flts[r[2:0]];
      load(op, instr, $random(seed), $random(seed), f,
           f == WLEU_EXC_NONE ? wleu_seg_e'(r[4:3]) : WLEU_SEG_USER_MAPPED);
    end
    apb(1'b0, `WLEU_STATUS_OFF, 32'h0);
    chk("status", {wb_count[15:0], 8'h0, last_exc, 4'h0}, rd & 32'hffff_00f1);
    conclude();
  end
endmodule
